// file: shared/pot_pkg.sv
// Purpose: constants and types shared by the background overflow timer
// Assumes: 100 MHz sys_clk, plain register port
// Notes: one configuration register, one overflow count register and a readable counter phase
package pot_pkg;
  localparam logic [1:0] CFG_ADDR = 2'h0;
  localparam logic [1:0] COUNT_ADDR = 2'h1;
  localparam logic [1:0] PHASE_ADDR = 2'h2;
  localparam int ENABLE_BIT = 0;
  localparam int PRESCALE_LO = 4;
  localparam int PRESCALE_HI = 5;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [1:0] BASE_DIV_LAST = 2'h3;

  typedef struct packed {
    logic [1:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } pot_req_type;

  typedef enum logic [1:0] {
    POT_DIV1 = 2'h0,
    POT_DIV2 = 2'h1,
    POT_DIV4 = 2'h2,
    POT_DIV8 = 2'h3
  } pot_prescale_type;
endpackage

// file: core/pot_timer.sv
// Purpose: free-running 16-bit background timer with overflow counter
// Assumes: synchronous active-high reset, registers on a plain port
// Notes: counting is frozen while clkEn is low
// Overview of operation
// - counter advances only when enabled, once per four clock periods times the prescale
// - bits 5:4 pick prescale 1, 2, 4 or 8
// - overflow word increments each time the 16-bit counter wraps
// - overflow word is 16 bits, readable, wraps naturally
// - counter runs freely, never stops or reloads on overflow
module pot_timer
  import pot_pkg::*;
(
  input wire logic sys_clk, // system clock
  input wire logic srst, // synchronous reset
  input wire logic clkEn, // clock enable
  input wire pot_req_type busReq, // register request
  output logic [15:0] rdata // read data, cycle after read
);

  ////////////////////////////////////////////////////////////////////
  logic [7:0] cfg;
  logic [1:0] baseDiv;
  logic [2:0] preDiv;
  logic [15:0] innerCount;
  logic [15:0] overflowCountWord;
  logic baseTick;
  logic preTick;
  logic enabled;
  logic cfgWr;
  pot_prescale_type prescale;

  assign enabled = cfg[ENABLE_BIT];
  assign cfgWr = clkEn && busReq.wr && busReq.addr == CFG_ADDR;
  assign prescale = pot_prescale_type'(cfg[PRESCALE_HI:PRESCALE_LO]);

  ////////////////////////////////////////////////////////////////////
  // configuration write
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cfg <= CFG_RESET;
    end else if (cfgWr) begin
      cfg <= busReq.wdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // base divide by four
  assign baseTick = enabled && baseDiv == BASE_DIV_LAST;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      baseDiv <= 2'h0;
    end else if (clkEn) begin
      if (!enabled) begin
        baseDiv <= 2'h0;
      end else begin
        baseDiv <= baseDiv + 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // prescaler
  always_comb begin
    unique case (prescale)
      POT_DIV1: preTick = baseTick;
      POT_DIV2: preTick = baseTick && preDiv[0] == 1'b1;
      POT_DIV4: preTick = baseTick && preDiv[1:0] == 2'h3;
      POT_DIV8: preTick = baseTick && preDiv == 3'h7;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      preDiv <= 3'h0;
    end else if (clkEn && baseTick) begin
      preDiv <= preDiv + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // counter and overflow word
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      innerCount <= COUNT_RESET;
    end else if (clkEn && preTick) begin
      innerCount <= innerCount + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      overflowCountWord <= COUNT_RESET;
    end else if (clkEn && preTick && innerCount == 16'hFFFF) begin
      overflowCountWord <= overflowCountWord + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read port
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rdata <= 16'h0000;
    end else if (clkEn) begin
      if (busReq.rd) begin
        unique case (busReq.addr)
          CFG_ADDR: rdata <= {8'h00, cfg};
          COUNT_ADDR: rdata <= overflowCountWord;
          PHASE_ADDR: rdata <= innerCount;
          default: rdata <= 16'h0000;
        endcase
      end else begin
        rdata <= 16'h0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  property p_base_gap;
    @(posedge sys_clk) disable iff (srst)
      (baseTick && clkEn) |=> !baseTick;
  endproperty
  a_base_gap: assert property (p_base_gap)
    else $error("base tick too frequent");

  property p_idle_when_off;
    @(posedge sys_clk) disable iff (srst)
      !enabled |=> $stable(innerCount);
  endproperty
  a_idle_when_off: assert property (p_idle_when_off)
    else $error("counter moved while disabled");

  property p_div1_rate;
    @(posedge sys_clk) disable iff (srst)
      (clkEn && preTick && prescale == POT_DIV1 && !cfgWr) ##1
        (clkEn && !cfgWr)[*3] |=> preTick;
  endproperty
  a_div1_rate: assert property (p_div1_rate)
    else $error("1:1 rate wrong");

  property p_wrap;
    @(posedge sys_clk) disable iff (srst)
      (clkEn && preTick && innerCount == 16'hFFFF) |=>
        innerCount == 16'h0000 &&
        overflowCountWord == $past(overflowCountWord) + 16'h0001;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("overflow not counted on wrap");

  property p_no_stray;
    @(posedge sys_clk) disable iff (srst)
      !(clkEn && preTick && innerCount == 16'hFFFF) &&
      !(clkEn && busReq.wr) |=> $stable(overflowCountWord);
  endproperty
  a_no_stray: assert property (p_no_stray)
    else $error("overflow word changed without wrap");

  property p_free_run;
    @(posedge sys_clk) disable iff (srst)
      (clkEn && preTick && innerCount != 16'hFFFF) |=>
        innerCount == $past(innerCount) + 16'h0001;
  endproperty
  a_free_run: assert property (p_free_run)
    else $error("counter did not advance");

  property p_reset;
    @(posedge sys_clk)
      srst |=> cfg == CFG_RESET && innerCount == COUNT_RESET &&
        overflowCountWord == COUNT_RESET;
  endproperty
  a_reset: assert property (p_reset)
    else $error("reset did not clear state");

  property p_read;
    @(posedge sys_clk) disable iff (srst)
      (clkEn && busReq.rd && busReq.addr == COUNT_ADDR) |=>
        rdata == $past(overflowCountWord);
  endproperty
  a_read: assert property (p_read)
    else $error("read data wrong");

  ////////////////////////////////////////////////////////////////////
  // further checks on rate, configuration and read port
  property p_base_rate;
    @(posedge sys_clk) disable iff (srst)
      (clkEn && baseTick && !cfgWr) ##1 (clkEn && !cfgWr)[*3]
        |=> baseTick;
  endproperty
  a_base_rate: assert property (p_base_rate)
    else $error("base tick not every fourth cycle");

  property p_base_clear;
    @(posedge sys_clk) disable iff (srst)
      (clkEn && !enabled) |=> baseDiv == 2'h0;
  endproperty
  a_base_clear: assert property (p_base_clear)
    else $error("base divider not held while disabled");

  property p_no_tick_off;
    @(posedge sys_clk) disable iff (srst)
      !enabled |-> !preTick;
  endproperty
  a_no_tick_off: assert property (p_no_tick_off)
    else $error("count tick while disabled");

  property p_tick_needs_base;
    @(posedge sys_clk) disable iff (srst)
      !baseTick |-> !preTick;
  endproperty
  a_tick_needs_base: assert property (p_tick_needs_base)
    else $error("count tick without base tick");

  property p_div2_gap;
    @(posedge sys_clk) disable iff (srst)
      (clkEn && preTick && prescale == POT_DIV2 && !cfgWr) |=>
        !preTick;
  endproperty
  a_div2_gap: assert property (p_div2_gap)
    else $error("1:2 tick too frequent");

  property p_div4_phase;
    @(posedge sys_clk) disable iff (srst)
      (preTick && prescale == POT_DIV4) |-> preDiv[1:0] == 2'h3;
  endproperty
  a_div4_phase: assert property (p_div4_phase)
    else $error("1:4 tick at wrong phase");

  property p_div8_phase;
    @(posedge sys_clk) disable iff (srst)
      (baseTick && prescale == POT_DIV8 && preDiv != 3'h7) |->
        !preTick;
  endproperty
  a_div8_phase: assert property (p_div8_phase)
    else $error("1:8 tick at wrong phase");

  property p_cfg_write;
    @(posedge sys_clk) disable iff (srst)
      cfgWr |=> cfg == $past(busReq.wdata[7:0]);
  endproperty
  a_cfg_write: assert property (p_cfg_write)
    else $error("configuration write lost");

  property p_cfg_hold;
    @(posedge sys_clk) disable iff (srst)
      !cfgWr |=> $stable(cfg);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("configuration changed without write");

  property p_frozen;
    @(posedge sys_clk) disable iff (srst)
      !clkEn |=> $stable(innerCount) && $stable(overflowCountWord) &&
        $stable(rdata);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("state moved while clock enable low");

  property p_rd_idle;
    @(posedge sys_clk) disable iff (srst)
      (clkEn && !busReq.rd) |=> rdata == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not cleared");

  property p_read_cfg;
    @(posedge sys_clk) disable iff (srst)
      (clkEn && busReq.rd && busReq.addr == CFG_ADDR) |=>
        rdata == {8'h00, $past(cfg)};
  endproperty
  a_read_cfg: assert property (p_read_cfg)
    else $error("configuration read wrong");

  property p_read_phase;
    @(posedge sys_clk) disable iff (srst)
      (clkEn && busReq.rd && busReq.addr == PHASE_ADDR) |=>
        rdata == $past(innerCount);
  endproperty
  a_read_phase: assert property (p_read_phase)
    else $error("counter read wrong");

  property p_read_unmapped;
    @(posedge sys_clk) disable iff (srst)
      (clkEn && busReq.rd && busReq.addr == 2'h3) |=>
        rdata == 16'h0000;
  endproperty
  a_read_unmapped: assert property (p_read_unmapped)
    else $error("unmapped read not zero");

  property p_reset_rdata;
    @(posedge sys_clk)
      srst |=> rdata == 16'h0000 && baseDiv == 2'h0 && preDiv == 3'h0;
  endproperty
  a_reset_rdata: assert property (p_reset_rdata)
    else $error("reset did not clear read data or dividers");

endmodule

// file: verification/tb.sv
// Purpose: self-checking bench for the background overflow timer
// Assumes: reads answer one cycle after the strobe
// Notes: counter phase is unknown by one tick, so reads check a range
module tb
  import pot_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, srst, clkEn, pend;
  pot_req_type busReq;
  logic [15:0] rdata;
  logic [15:0] qLo[$], qHi[$];
  int n_mismatch, cmp_count, k, p;
  pot_timer u_pot_timer (.sys_clk(sys_clk), .srst(srst), .clkEn(clkEn),
    .busReq(busReq), .rdata(rdata));
  initial begin
    sys_clk = 0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic stop_test();
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(logic [15:0] lo, logic [15:0] hi);
    cmp_count++;
    if ((rdata >= lo && rdata <= hi) !== 1'b1) begin
      n_mismatch++;
      $display("Error %0t read %h outside %h..%h", $time, rdata, lo, hi);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  // monitor: compare the oldest note in the cycle after each read
  always @(posedge sys_clk) begin
    if (pend && qLo.size() > 0) chk(qLo.pop_front(), qHi.pop_front());
    pend <= (busReq.rd === 1'b1);
  end
  task automatic wr(logic [1:0] a, logic [15:0] d);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
  endtask
  task automatic rd(logic [1:0] a, logic [15:0] lo, logic [15:0] hi);
    qLo.push_back(lo);
    qHi.push_back(hi);
    busReq <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
  endtask
  task automatic reset();
    busReq <= '0;
    srst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clkEn = 1'b1;
    pend = 1'b0;
    void'($urandom(32'hA84AFCD9));
    reset();
    for (int a = 0; a < 4; a++) rd(2'(a), 16'h0000, 16'h0000);
    wr(CFG_ADDR, 16'h0080);
    busReq <= '0;
    repeat (40) @(posedge sys_clk);
    rd(PHASE_ADDR, 16'h0000, 16'h0000);
    for (p = 0; p < 4; p++) begin
      reset();
      k = 8 + $urandom % 8;
      wr(CFG_ADDR, {8'h00, 2'h2, 2'(p), 4'h1});
      busReq <= '0;
      clkEn <= 1'b0;
      repeat (1 + $urandom % 9) @(posedge sys_clk);
      clkEn <= 1'b1;
      repeat (4 * (1 << p) * k - 1) @(posedge sys_clk);
      rd(PHASE_ADDR, 16'(k - 1), 16'(k));
      wr(COUNT_ADDR, 16'($urandom));
      rd(COUNT_ADDR, 16'h0000, 16'h0000);
      rd(CFG_ADDR, {8'h00, 2'h2, 2'(p), 4'h1},
        {8'h00, 2'h2, 2'(p), 4'h1});
      rd(2'h3, 16'h0000, 16'h0000);
    end
    busReq <= '0;
    repeat (3) @(posedge sys_clk);
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    stop_test();
  end
endmodule
